// ==== hw/vid_dispatch.sv ====
/*
 Vectored interrupt dispatch: priority pick, vector address, context
 save and restore, critical section, per-level scratch registers over
 AXI4-Lite. Assumes the pipeline reports raw cause events and acts on
 the dispatch and return outputs in the cycle after they are raised.
*/
module vid_dispatch
	import vid_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [46:0]       cause_events,
	input  wire logic [3:0]        swint_exec,
	input  wire logic [31:0]       current_pc,
	input  wire logic              iret_exec,
	input  wire logic [1:0]        sw_level,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output vid_dispatch_type       dispatch_q,
	output vid_return_type         return_q,
	output logic [1:0]             level_q,
	output logic                   crit_q
);
	logic [46:0] pend_q;
	logic [46:0] mask_q;
	logic [93:0] dest_q;
	logic [31:0] ctx_pc_q   [num_levels_c];
	logic [2:0]  ctx_lvl_q  [num_levels_c];
	logic [31:0] save_q     [num_levels_c*4];
	logic [46:0] raw;
	logic [46:0] live;
	logic        hit;
	logic [5:0]  pick;
	logic [1:0]  dlvl;
	logic        viol;
	logic        take;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        awh_q;
	logic        wh_q;
	logic        wr_go;
	logic        wr_save;
	logic        wr_bad;
	logic [3:0]  widx;
	logic        rd_save;
	logic        rd_bad;
	logic [3:0]  ridx;
	logic [31:0] rval;
	logic [31:0] wmask;

	// Cause assembly
	always_comb
	begin
		raw = cause_events;
		raw = raw & ~reserved_causes_c;
		for (int i = 0; i < 4; i++)
			raw[6'(swint_base_cause + 6'(3 - i))] = swint_exec[i] |
				cause_events[6'(swint_base_cause + 6'(3 - i))];
		raw[protection_violation_cause] = cause_events[3] | viol;
	end

	assign live = pend_q & ~mask_q;

	// Lowest-numbered winner
	always_comb
	begin
		hit  = 1'b0;
		pick = 6'h00;
		for (int i = num_causes_c - 1; i >= 0; i--)
			if (live[i])
			begin
				hit  = 1'b1;
				pick = 6'(i);
			end
		dlvl = dest_q[2*pick +: 2];
	end

	assign take = hit && !crit_q && !iret_exec;

	// Pending causes, set wins over dispatch clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pend_q <= 47'h0;
		else
			pend_q <= (pend_q & ~(take ? (47'h1 << pick) : 47'h0)) | raw;
	end

	// Level and critical section
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			level_q <= 2'h0;
			crit_q  <= 1'b0;
		end
		else if (take)
		begin
			level_q <= dlvl;
			crit_q  <= 1'b1;
		end
		else if (iret_exec)
		begin
			level_q <= ctx_lvl_q[level_q][1:0];
			crit_q  <= ctx_lvl_q[level_q][2];
		end
		else if (wr_go && aw_q == crit_off_c)
			crit_q <= w_q[0];
	end

	// Saved context pair per destination level
	generate
		for (genvar l = 0; l < num_levels_c; l++)
		begin : g_ctx
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					ctx_pc_q[l]  <= 32'h0;
					ctx_lvl_q[l] <= 3'h0;
				end
				else if (take && dlvl == 2'(l))
				begin
					ctx_pc_q[l]  <= current_pc;
					ctx_lvl_q[l] <= {crit_q, level_q};
				end
			end
		end
	endgenerate

	// Dispatch and return pulses
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dispatch_q <= '0;
			return_q   <= '0;
		end
		else
		begin
			dispatch_q.valid <= take;
			dispatch_q.cause <= pick;
			dispatch_q.level <= dlvl;
			dispatch_q.pc    <= vector_table_base
				+ (32'(dlvl) << level_shift_c)
				+ (32'(pick) << cause_shift_c);
			return_q.valid <= iret_exec && !take;
			return_q.pc    <= ctx_pc_q[level_q];
			return_q.level <= ctx_lvl_q[level_q][1:0];
		end
	end

	// AXI4-Lite write side
	assign wr_go   = awh_q && wh_q && !s_axi_bvalid;
	assign wr_save = aw_q[7:6] == save_base_off_c[7:6];
	assign widx    = aw_q[5:2];
	assign wr_bad  = wr_save && (sw_level < widx[3:2]);
	assign viol    = (wr_go && wr_bad) ||
		(s_axi_arvalid && s_axi_arready && rd_bad);
	always_comb
		for (int b = 0; b < 4; b++)
			wmask[8*b +: 8] = {8{ws_q[b]}};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awh_q         <= 1'b0;
			wh_q          <= 1'b0;
			aw_q          <= 8'h00;
			w_q           <= 32'h0;
			ws_q          <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= resp_okay_c;
		end
		else
		begin
			s_axi_awready <= !awh_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !wh_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awh_q <= 1'b1;
				aw_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wh_q <= 1'b1;
				w_q  <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				awh_q        <= 1'b0;
				wh_q         <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_bad ? resp_slverr_c : resp_okay_c;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Mask, destination and scratch storage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mask_q <= mask_reset_c;
			dest_q <= dest_reset_c;
		end
		else if (wr_go)
			case (aw_q)
				mask_lo_off_c: mask_q[31:0] <= (mask_q[31:0] & ~wmask)
					| (w_q & wmask);
				mask_hi_off_c: mask_q[46:32] <= (mask_q[46:32]
					& ~wmask[14:0]) | (w_q[14:0] & wmask[14:0]);
				dest_lo_off_c: dest_q[31:0] <= w_q;
				dest_hi_off_c: dest_q[93:32] <= {30'h0, w_q};
				default: ;
			endcase
	end

	generate
		for (genvar s = 0; s < num_levels_c*4; s++)
		begin : g_save
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					save_q[s] <= 32'h0;
				else if (wr_go && wr_save && !wr_bad && widx == 4'(s))
					save_q[s] <= (save_q[s] & ~wmask) | (w_q & wmask);
			end
		end
	endgenerate

	// AXI4-Lite read side
	assign rd_save = s_axi_araddr[7:6] == save_base_off_c[7:6];
	assign ridx    = s_axi_araddr[5:2];
	assign rd_bad  = rd_save && (sw_level < ridx[3:2]);

	always_comb
	begin
		rval = 32'h0;
		if (rd_save)
			rval = rd_bad ? 32'h0 : save_q[ridx];
		else if (s_axi_araddr[7:5] == ctx_base_off_c[7:5])
			rval = s_axi_araddr[2] ? {29'h0, ctx_lvl_q[s_axi_araddr[4:3]]}
				: ctx_pc_q[s_axi_araddr[4:3]];
		else
			case (s_axi_araddr)
				mask_lo_off_c: rval = mask_q[31:0];
				mask_hi_off_c: rval = {17'h0, mask_q[46:32]};
				crit_off_c:    rval = {31'h0, crit_q};
				status_off_c:  rval = {24'h0, hit, pick, 1'b0};
				dest_lo_off_c: rval = dest_q[31:0];
				dest_hi_off_c: rval = dest_q[63:32];
				default:       rval = 32'h0;
			endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= resp_okay_c;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rval;
				s_axi_rresp  <= rd_bad ? resp_slverr_c : resp_okay_c;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule : vid_dispatch

// ==== hw/vid_pkg.sv ====
/*
 Package for the vectored interrupt dispatch block: cause numbers,
 vector address constants, register map and bus payload types.
 Assumes a single core clock and an AXI4-Lite master outside.
*/
package vid_pkg;
	localparam int unsigned  num_causes_c            = 47;
	localparam int unsigned  num_levels_c            = 4;
	localparam logic [5:0]   protection_violation_cause = 6'h03;
	localparam logic [5:0]   static_net_access_cause = 6'h04;
	localparam logic [5:0]   io_net_access_cause     = 6'h05;
	localparam logic [5:0]   user_net_access_cause   = 6'h06;
	localparam logic [5:0]   swint_base_cause        = 6'h0b;
	localparam logic [5:0]   data_xlate_miss_cause   = 6'h10;
	localparam logic [5:0]   data_xlate_error_cause  = 6'h11;
	localparam logic [5:0]   dma_xlate_miss_cause    = 6'h12;
	localparam logic [5:0]   dma_xlate_error_cause   = 6'h13;
	localparam logic [5:0]   user_net_message_ready_cause = 6'h20;
	localparam logic [5:0]   fetch_space_id_cause    = 6'h28;
	localparam logic [5:0]   data_space_id_cause     = 6'h29;
	localparam logic [5:0]   dma_space_id_cause      = 6'h2a;
	localparam logic [5:0]   dma_privilege_cause     = 6'h2c;
	localparam logic [46:0]  reserved_causes_c       = 47'h2800_0030_0000;
	localparam logic [31:0]  vector_table_base       = 32'hfc00_0000;
	localparam int unsigned  level_shift_c           = 24;
	localparam int unsigned  cause_shift_c           = 8;
	// Register map, byte addresses
	localparam logic [7:0]   mask_lo_off_c      = 8'h00;
	localparam logic [7:0]   mask_hi_off_c      = 8'h04;
	localparam logic [7:0]   crit_off_c         = 8'h08;
	localparam logic [7:0]   status_off_c       = 8'h0c;
	localparam logic [7:0]   dest_lo_off_c      = 8'h10;
	localparam logic [7:0]   dest_hi_off_c      = 8'h14;
	localparam logic [7:0]   ctx_base_off_c     = 8'h20;
	localparam logic [7:0]   save_base_off_c    = 8'h40;
	localparam logic [46:0]  mask_reset_c       = 47'h7fff_ffff_ffff;
	localparam logic [93:0]  dest_reset_c       = 94'h0;
	localparam logic [1:0]   resp_okay_c        = 2'b00;
	localparam logic [1:0]   resp_slverr_c      = 2'b10;

	typedef struct packed {
		logic        valid;
		logic [5:0]  cause;
		logic [1:0]  level;
		logic [31:0] pc;
	} vid_dispatch_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] pc;
		logic [1:0]  level;
	} vid_return_type;
endpackage : vid_pkg

// ==== tb/vid_dispatch_chk.sv ====
/* Port checker for vid_dispatch.
 Bound to every instance; one clock. */
module vid_dispatch_chk
	import vid_pkg::*;
(
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             iret_exec,
	input wire logic             s_axi_rvalid,
	input wire logic [1:0]       s_axi_rresp,
	input wire logic [31:0]      s_axi_rdata,
	input wire vid_dispatch_type dispatch_q,
	input wire vid_return_type   return_q,
	input wire logic [1:0]       level_q,
	input wire logic             crit_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_vec_addr:
		assert property (dispatch_q.valid |-> dispatch_q.pc == 32'hfc00_0000
			+ {dispatch_q.level, 24'h0} + {dispatch_q.cause, 8'h0})
		else $error("vector address wrong");
	a_crit_set:
		assert property (dispatch_q.valid |-> crit_q && !$past(crit_q))
		else $error("flag not set on entry");
	a_disp_pulse:
		assert property (dispatch_q.valid |=> !dispatch_q.valid)
		else $error("dispatch while flag set");
	a_level_dest:
		assert property (dispatch_q.valid |-> level_q == dispatch_q.level)
		else $error("level not destination");
	a_no_resv:
		assert property (dispatch_q.valid |->
			!(dispatch_q.cause inside {6'h2b, 6'h2d}))
		else $error("reserved cause raised");
	a_ret_cause:
		assert property (return_q.valid |-> $past(iret_exec))
		else $error("return without request");
	a_ret_level:
		assert property (return_q.valid |-> level_q == return_q.level)
		else $error("level not restored");
	a_slverr_zero:
		assert property (s_axi_rvalid && s_axi_rresp == resp_slverr_c
			|-> s_axi_rdata == 32'h0)
		else $error("refused read gave data");
endmodule : vid_dispatch_chk
bind vid_dispatch vid_dispatch_chk chk_u (.aclk, .aresetn, .iret_exec,
	.s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .dispatch_q, .return_q,
	.level_q, .crit_q);

// ==== tb/vid_dispatch_tb.sv ====
/* Bench for vid_dispatch: bus tasks and cause sequences.
 Pipeline side played by vid_pipe_model. */
module vid_dispatch_tb
	import vid_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, go, ret_in, iret_exec, crit_q;
	logic [46:0] ev_in, cause_events;
	logic [3:0] sw_in, swint_exec, s_axi_wstrb;
	logic [31:0] pc_in, current_pc, s_axi_wdata, s_axi_rdata;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [1:0] sw_level, level_q, s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	vid_dispatch_type dispatch_q;
	vid_return_type return_q;
	int num_errors, samples_checked, cyc, i;
	int ord [11] = '{4, 5, 6, 16, 17, 18, 19, 40, 41, 42, 44};
	int n_disp, disp_used;
	vid_dispatch_type cap_q;
	logic [1:0] cap_lvl;
	logic cap_crit;
	vid_dispatch dut_u (.aclk, .aresetn, .cause_events, .swint_exec,
		.current_pc, .iret_exec, .sw_level, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dispatch_q,
		.return_q, .level_q, .crit_q);
	vid_pipe_model pm_u (.aclk, .go, .ev_in, .sw_in, .ret_in, .pc_in,
		.cause_events, .swint_exec, .iret_exec, .current_pc);
	// Catch every entry, even while a bus task is running
	always @(posedge aclk)
		if (aresetn === 1'b1 && dispatch_q.valid === 1'b1)
		begin
			n_disp <= n_disp + 1;
			cap_q <= dispatch_q;
			cap_lvl <= level_q;
			cap_crit <= crit_q;
		end
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task end_sim;
		$display("Checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			end_sim();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(r), 32'(s_axi_bresp));
		@(posedge aclk);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", 32'(r), 32'(s_axi_rresp));
		@(posedge aclk);
	endtask : rd
	task fire(input logic [46:0] e, input logic [3:0] s, input logic r);
		@(posedge aclk);
		ev_in <= e;
		sw_in <= s;
		ret_in <= r;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
	endtask : fire
	task wdisp(input logic [5:0] c, input logic [1:0] l);
		int n;
		n = 0;
		while (n_disp == disp_used && n++ < 30)
			@(negedge aclk);
		chk("entries", 32'(disp_used + 1), 32'(n_disp));
		disp_used = n_disp;
		chk("cause", 32'(c), 32'(cap_q.cause));
		chk("vector", 32'hfc00_0000 + {l, 24'h0} + {c, 8'h0},
			cap_q.pc);
		chk("slot", 32'h0, 32'(cap_q.pc[7:0]));
		chk("level", 32'(l), 32'(cap_lvl));
		chk("crit", 32'h1, 32'(cap_crit));
		@(posedge aclk);
	endtask : wdisp
	task nodisp;
		repeat (10) @(negedge aclk) chk("idle", 0, 32'(dispatch_q.valid));
		chk("no entry", 32'(disp_used), 32'(n_disp));
		@(posedge aclk);
	endtask : nodisp
	task wret(input logic [31:0] pc);
		int n;
		n = 0;
		do
			@(negedge aclk);
		while (return_q.valid !== 1'b1 && n++ < 30);
		chk("ret seen", 32'h1, 32'(return_q.valid));
		chk("ret pc", pc, return_q.pc);
		chk("ret level", 0, 32'(level_q));
		chk("ret crit", 0, 32'(crit_q));
		@(posedge aclk);
	endtask : wret
	initial
	begin
		{aresetn, go, ret_in, sw_level, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ev_in, sw_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{num_errors, samples_checked, cyc} = '0;
		s_axi_wstrb = 4'hf;
		pc_in = 32'h1000_0040;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(mask_lo_off_c, 32'hffff_ffff, resp_okay_c);
		rd(mask_hi_off_c, 32'h0000_7fff, resp_okay_c);
		rd(8'hfc, 32'h0, resp_okay_c);
		fire(47'h1 << 32, 4'h0, 1'b0);
		nodisp();
		wr(mask_hi_off_c, 32'h0, resp_okay_c);
		wdisp(6'h20, 2'h0);
		rd(ctx_base_off_c, 32'h1000_0040, resp_okay_c);
		rd(8'h24, 32'h0, resp_okay_c);
		fire('0, 4'h0, 1'b1);
		wret(32'h1000_0040);
		wr(mask_lo_off_c, 32'h0, resp_okay_c);
		wr(dest_lo_off_c, 32'h80, resp_okay_c);
		fire(47'h3f00_000f_0070, 4'h0, 1'b0);
		for (i = 0; i < 11; i++)
		begin
			wdisp(6'(ord[i]), 2'h0);
			if (i == 0)
				nodisp();
			wr(crit_off_c, 32'h0, resp_okay_c);
		end
		nodisp();
		fire('0, 4'hf, 1'b0);
		for (i = 0; i < 4; i++)
		begin
			wdisp(6'(11 + i), 2'h0);
			wr(crit_off_c, 32'h0, resp_okay_c);
		end
		wr(crit_off_c, 32'h1, resp_okay_c);
		sw_level <= 2'h3;
		wr(8'h70, 32'hcafe_0003, resp_okay_c);
		sw_level <= 2'h0;
		wr(8'h70, 32'h1234_5678, resp_slverr_c);
		rd(8'h70, 32'h0, resp_slverr_c);
		wr(save_base_off_c, 32'h5a5a_0000, resp_okay_c);
		sw_level <= 2'h3;
		rd(8'h70, 32'hcafe_0003, resp_okay_c);
		rd(save_base_off_c, 32'h5a5a_0000, resp_okay_c);
		pc_in <= 32'h2000_0080;
		wr(crit_off_c, 32'h0, resp_okay_c);
		wdisp(protection_violation_cause, 2'h2);
		rd(8'h30, 32'h2000_0080, resp_okay_c);
		rd(ctx_base_off_c, 32'h1000_0040, resp_okay_c);
		fire('0, 4'h0, 1'b1);
		wret(32'h2000_0080);
		end_sim();
	end
endmodule : vid_dispatch_tb

// ==== tb/vid_pipe_model.sv ====
/* Pipeline and cause source model.
 Bench requests become one-cycle pulses. */
module vid_pipe_model
	import vid_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        go,
	input  wire logic [46:0] ev_in,
	input  wire logic [3:0]  sw_in,
	input  wire logic        ret_in,
	input  wire logic [31:0] pc_in,
	output logic [46:0]      cause_events,
	output logic [3:0]       swint_exec,
	output logic             iret_exec,
	output logic [31:0]      current_pc
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge aclk)
	begin
		cause_events <= go ? ev_in : '0;
		swint_exec   <= go ? sw_in : '0;
		iret_exec    <= go & ret_in;
		current_pc   <= pc_in;
	end
endmodule : vid_pipe_model
